// *** srw_cfg.svh ***
// Constants for the supervisor reset and watchdog block.
// Assumes a 20 MHz system clock and a 10.24 kHz internal timebase.
`ifndef SRW_CFG_SVH
`define SRW_CFG_SVH

`define SRW_SYS_CLK_HZ      20000000
`define SRW_INT_OSC_HZ      10240
`define SRW_OSC_DIV         (`SRW_SYS_CLK_HZ / `SRW_INT_OSC_HZ)

// Internal oscillator times in ms
`define SRW_WD_FAST_MS      100
`define SRW_WD_SLOW_MS      1600
`define SRW_RST_SHORT_MS    50
`define SRW_RST_LONG_MS     200
`define SRW_MS_TICKS(ms)    ((ms) * `SRW_INT_OSC_HZ / 1000)

// External timebase counts in ticks
`define SRW_EXT_WD_NORM     1024
`define SRW_EXT_WD_POST     4096
`define SRW_EXT_RST_SHORT   512
`define SRW_EXT_RST_LONG    2048

// Register map
`define SRW_ADDR_CTRL       4'h0
`define SRW_ADDR_STATUS     4'h4
`define SRW_CTRL_LONG_BIT   0
`define SRW_CTRL_RESET      1'b0
`define SRW_ST_RESET_N      0
`define SRW_ST_LOW_SUPPLY_N 1
`define SRW_ST_WD_EXP_N     2
`define SRW_ST_BACKUP       3
`define SRW_ST_POST_LONG    4
`define SRW_ST_EXT_TB       5

`endif

// *** srw_pkg.sv ***
// Types shared by the supervisor reset and watchdog block.
// Assumes srw_cfg.svh holds the numeric constants.
package srw_pkg;

  typedef enum logic [2:0] {
    SRW_HOLD  = 3'b001,
    SRW_PULSE = 3'b010,
    SRW_RUN   = 3'b100
  } srw_state_type;

  typedef struct packed {
    logic mid;
    logic level;
  } srw_kick_type;

  typedef struct packed {
    logic below_threshold;
    logic main_below_backup;
    logic main_above_backup;
  } srw_supply_type;

endpackage

// *** srw_core.sv ***
// Supervisor: supply reset, watchdog, backup switch, Wishbone registers.
// Assumes inputs synchronous to sys_clk_in and comparators as flags.
//
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "srw_cfg.svh"

module srw_core
  import srw_pkg::*;
#(
  parameter int CNT_W         = 16,
  parameter int OSC_DIV       = `SRW_OSC_DIV,
  parameter int WD_FAST       = `SRW_MS_TICKS(`SRW_WD_FAST_MS),
  parameter int WD_SLOW       = `SRW_MS_TICKS(`SRW_WD_SLOW_MS),
  parameter int RST_SHORT     = `SRW_MS_TICKS(`SRW_RST_SHORT_MS),
  parameter int RST_LONG      = `SRW_MS_TICKS(`SRW_RST_LONG_MS),
  parameter int EXT_WD_NORM   = `SRW_EXT_WD_NORM,
  parameter int EXT_WD_POST   = `SRW_EXT_WD_POST,
  parameter int EXT_RST_SHORT = `SRW_EXT_RST_SHORT,
  parameter int EXT_RST_LONG  = `SRW_EXT_RST_LONG
) (
  input  wire logic           sys_clk_in,
  input  wire logic           rstn_in,
  input  wire srw_supply_type supply_in,
  input  wire srw_kick_type   watchdog_kick_in,
  input  wire logic           timebase_source_select_in,
  input  wire logic           timebase_input_in,
  input  wire logic           wb_cyc_in,
  input  wire logic           wb_stb_in,
  input  wire logic           wb_we_in,
  input  wire logic [3:0]     wb_adr_in,
  input  wire logic [3:0]     wb_sel_in,
  input  wire logic [31:0]    wb_dat_in,
  output logic [31:0]         wb_dat_out,
  output logic                wb_ack_out,
  output logic                reset_n_out,
  output logic                reset_out,
  output logic                low_supply_n_out,
  output logic                watchdog_expired_n_out,
  output logic                backup_active_out
);

  localparam int MAXC = (1 << CNT_W) - 1;

  // Elaboration check on the count parameters
  if (CNT_W < 2 || CNT_W > 30 || OSC_DIV < 2 || OSC_DIV > MAXC ||
      WD_SLOW > MAXC || WD_FAST < 1 || RST_SHORT < 1 || RST_LONG > MAXC ||
      EXT_WD_POST > MAXC || EXT_WD_NORM < 1 ||
      EXT_RST_SHORT < 1 || EXT_RST_LONG > MAXC) begin : g_bad_params
    $error("srw_core: count parameters out of range");
  end

  function automatic logic [CNT_W-1:0] cw(input int v);
    cw = v[CNT_W-1:0];
  endfunction

  // Timebase state
  logic [CNT_W-1:0] div_cnt;
  logic [CNT_W-1:0] next_div_cnt;
  logic             tb_prev;
  logic             tick;

  // Supervisor state
  srw_state_type    state;
  srw_state_type    next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             post_long;
  logic             next_post_long;
  srw_kick_type     kick_prev;
  logic             kick_edge;
  logic             timeout;
  logic [CNT_W-1:0] wd_limit;
  logic [CNT_W-1:0] rst_limit;
  logic             use_ext;
  logic             next_reset_n;
  logic             next_wdo_n;
  logic             next_backup;

  // Bus state
  logic             long_pulse;
  logic             next_long_pulse;
  logic             next_ack;
  logic [31:0]      next_dat;

  assign use_ext = !timebase_source_select_in;

  always_comb begin
    next_div_cnt = '0;
    tick = 1'b0;
    if (use_ext) begin
      tick = timebase_input_in && !tb_prev;
    end else if (div_cnt == cw(OSC_DIV - 1)) begin
      tick = 1'b1;
    end else begin
      next_div_cnt = div_cnt + cw(1);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      div_cnt <= '0;
      tb_prev <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      tb_prev <= timebase_input_in;
    end
  end

  // Limits in timebase ticks
  always_comb begin
    if (post_long) begin
      wd_limit = use_ext ? cw(EXT_WD_POST) : cw(WD_SLOW);
    end else if (use_ext) begin
      wd_limit = cw(EXT_WD_NORM);
    end else begin
      wd_limit = timebase_input_in ? cw(WD_SLOW) : cw(WD_FAST);
    end
    if (use_ext) begin
      rst_limit = long_pulse ? cw(EXT_RST_LONG) : cw(EXT_RST_SHORT);
    end else begin
      rst_limit = long_pulse ? cw(RST_LONG) : cw(RST_SHORT);
    end
  end

  // Decoded kick edges, ignoring moves to or from mid level
  assign kick_edge = !watchdog_kick_in.mid && !kick_prev.mid &&
                     (watchdog_kick_in.level != kick_prev.level);
  assign timeout = (state == SRW_RUN) && tick && !kick_edge &&
                   !watchdog_kick_in.mid && (cnt + cw(1) >= wd_limit);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_post_long = post_long;
    case (state)
      SRW_HOLD: begin
        next_cnt = '0;
        next_post_long = 1'b1;
        if (!supply_in.below_threshold) begin
          next_state = SRW_PULSE;
        end
      end
      SRW_PULSE: begin
        next_post_long = 1'b1;
        if (supply_in.below_threshold) begin
          next_state = SRW_HOLD;
          next_cnt = '0;
        end else if (tick) begin
          next_cnt = cnt + cw(1);
          if (cnt + cw(1) >= rst_limit) begin
            next_state = SRW_RUN;
            next_cnt = '0;
          end
        end
      end
      SRW_RUN: begin
        if (supply_in.below_threshold) begin
          next_state = SRW_HOLD;
          next_cnt = '0;
        end else if (kick_edge) begin
          next_cnt = '0;
          next_post_long = 1'b0;
        end else if (watchdog_kick_in.mid) begin
          next_cnt = '0;
        end else if (timeout) begin
          next_state = SRW_PULSE;
          next_cnt = '0;
          next_post_long = 1'b1;
        end else if (tick) begin
          next_cnt = cnt + cw(1);
        end
      end
      default: begin
        next_state = SRW_HOLD;
        next_cnt = '0;
        next_post_long = 1'b1;
      end
    endcase
  end

  // Output values
  always_comb begin
    next_reset_n = (next_state == SRW_RUN);
    next_wdo_n = watchdog_expired_n_out;
    if (supply_in.below_threshold || watchdog_kick_in.mid || kick_edge) begin
      next_wdo_n = 1'b1;
    end else if (timeout) begin
      next_wdo_n = 1'b0;
    end
    next_backup = backup_active_out;
    if (supply_in.main_below_backup) begin
      next_backup = 1'b1;
    end else if (supply_in.main_above_backup) begin
      next_backup = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      state <= SRW_HOLD;
      cnt <= '0;
      post_long <= 1'b1;
      kick_prev <= '{mid: 1'b1, level: 1'b0};
      reset_n_out <= 1'b0;
      reset_out <= 1'b1;
      low_supply_n_out <= 1'b0;
      watchdog_expired_n_out <= 1'b1;
      backup_active_out <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      post_long <= next_post_long;
      kick_prev <= watchdog_kick_in;
      reset_n_out <= next_reset_n;
      reset_out <= !next_reset_n;
      low_supply_n_out <= !supply_in.below_threshold;
      watchdog_expired_n_out <= next_wdo_n;
      backup_active_out <= next_backup;
    end
  end

  // Wishbone slave, one registered answer per request, one cycle after the strobe
  always_comb begin
    next_ack = wb_cyc_in && wb_stb_in && !wb_ack_out;
    next_long_pulse = long_pulse;
    next_dat = '0;
    if (next_ack && wb_we_in && wb_sel_in[0] &&
        wb_adr_in == `SRW_ADDR_CTRL) begin
      next_long_pulse = wb_dat_in[`SRW_CTRL_LONG_BIT];
    end
    if (next_ack && !wb_we_in) begin
      case (wb_adr_in)
        `SRW_ADDR_CTRL: begin
          next_dat[`SRW_CTRL_LONG_BIT] = long_pulse;
        end
        `SRW_ADDR_STATUS: begin
          next_dat[`SRW_ST_RESET_N] = reset_n_out;
          next_dat[`SRW_ST_LOW_SUPPLY_N] = low_supply_n_out;
          next_dat[`SRW_ST_WD_EXP_N] = watchdog_expired_n_out;
          next_dat[`SRW_ST_BACKUP] = backup_active_out;
          next_dat[`SRW_ST_POST_LONG] = post_long;
          next_dat[`SRW_ST_EXT_TB] = use_ext;
        end
        default: begin
          next_dat = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      long_pulse <= `SRW_CTRL_RESET;
      wb_ack_out <= 1'b0;
      wb_dat_out <= '0;
    end else begin
      long_pulse <= next_long_pulse;
      wb_ack_out <= next_ack;
      wb_dat_out <= next_dat;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);

  a_reset_pair_complement: assert property (
    reset_out == !reset_n_out)
    else $error("reset outputs not complementary");

  a_low_supply_tracks: assert property (
    supply_in.below_threshold |=> !low_supply_n_out)
    else $error("low supply status not low");

  a_low_supply_clears: assert property (
    !supply_in.below_threshold |=> low_supply_n_out)
    else $error("low supply status not released");

  a_supply_holds_reset: assert property (
    supply_in.below_threshold |=> !reset_n_out)
    else $error("reset released with bad supply");

  a_wdo_forced_high: assert property (
    supply_in.below_threshold |=> watchdog_expired_n_out)
    else $error("expired output low during low supply");

  a_mid_disables_wd: assert property (
    watchdog_kick_in.mid |=> watchdog_expired_n_out && state != SRW_PULSE
      || $past(state) != SRW_RUN || $past(supply_in.below_threshold))
    else $error("watchdog active with mid kick input");

  a_kick_sets_wdo: assert property (
    kick_edge |=> watchdog_expired_n_out)
    else $error("kick did not clear expired output");

  a_timeout_pulses: assert property (
    $fell(watchdog_expired_n_out) |-> !reset_n_out && post_long)
    else $error("expiry without reset pulse");

  a_release_after_tick: assert property (
    $rose(reset_n_out) |-> $past(tick) && $past(state) == SRW_PULSE
      && $past(cnt) + cw(1) >= $past(rst_limit))
    else $error("reset released early");

  a_release_long_wd: assert property (
    $rose(reset_n_out) |-> post_long)
    else $error("short timeout after reset");

  a_backup_switch: assert property (
    supply_in.main_below_backup |=> backup_active_out)
    else $error("backup not selected");

  c_power_up_release: cover property ($rose(reset_n_out));
  c_watchdog_timeout: cover property ($fell(watchdog_expired_n_out));
  c_backup_on: cover property ($rose(backup_active_out));

endmodule

`default_nettype wire

// *** srw_host.sv ***
// Host model: toggles the kick input every GAP cycles while enabled.
// Assumes srw_pkg and the supervisor's own clock.
`timescale 1ns/10ps
`default_nettype none
module srw_host
  import srw_pkg::*;
#(
  parameter int GAP = 6
) (
  input  wire logic    clk_in,
  input  wire logic    run_in,
  output srw_kick_type kick_out
);
  int cnt;
  initial begin
    kick_out = '0;
    cnt = 0;
  end
  always @(posedge clk_in) begin
    cnt <= (cnt + 1) % GAP;
    if (run_in && cnt == 0) kick_out.level <= ~kick_out.level;
  end
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for srw_core with shortened internal timebase tick counts.
// Assumes srw_host drives the kick input while host_en is high.
`timescale 1ns/10ps
`default_nettype none
`include "srw_cfg.svh"
module testbench
  import srw_pkg::*;
;
  logic clk, rstn, sel, tbi, ext, we, wcyc, stb, host_en, ack, tb_lvl;
  logic rn, r, lsn, wen, bk;
  logic [3:0] adr, wsel;
  logic [31:0] wdat, dout, q;
  srw_supply_type sup;
  srw_kick_type kick, hkick, kmux;
  int error_cnt, checks, cyc_n, n, bad;
  assign kmux = host_en ? hkick : kick;
  srw_core #(.OSC_DIV(4), .WD_FAST(8), .WD_SLOW(16), .RST_SHORT(4),
    .RST_LONG(6)) dut (.sys_clk_in(clk), .rstn_in(rstn),
    .supply_in(sup), .watchdog_kick_in(kmux),
    .timebase_source_select_in(sel), .timebase_input_in(tbi),
    .wb_cyc_in(wcyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(wsel), .wb_dat_in(wdat), .wb_dat_out(dout),
    .wb_ack_out(ack), .reset_n_out(rn), .reset_out(r),
    .low_supply_n_out(lsn), .watchdog_expired_n_out(wen),
    .backup_active_out(bk));
  srw_host host (.clk_in(clk), .run_in(host_en), .kick_out(hkick));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rng(input int v, input int lo, input int hi);
    chk(32'(v >= lo && v <= hi), 32'h0000_0001);
  endtask
  task automatic wait_for(input int w, input logic v, output int c);
    c = 0;
    while (((w == 0) ? rn : wen) !== v && c < 10000) begin
      @(posedge clk);
      c++;
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    int k;
    @(posedge clk);
    wcyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; wsel <= s;
    k = 0;
    do begin @(posedge clk); k++; end while (ack !== 1'b1 && k < 50);
    q = dout;
    chk(ack, 32'h0000_0001);
    wcyc <= 0; stb <= 0; we <= 0;
  endtask
  task automatic supply_pulse(input int lo, input int hi);
    @(posedge clk) sup.below_threshold <= 1;
    repeat (2) @(posedge clk);
    chk({lsn, rn, r, wen}, 32'h0000_0003);
    sup.below_threshold <= 0;
    repeat (2) @(posedge clk);
    chk(lsn, 1);
    wait_for(0, 1, n);
    rng(n, lo, hi);
  endtask
  task summarize;
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    tbi <= ext ? ~tbi : tb_lvl;
    cyc_n++;
    if (cyc_n > 20000) begin
      error_cnt++;
      summarize;
    end
  end
  task automatic t_power_up;
    wait_for(0, 1, n);
    rng(n, 11, 19);
    @(posedge clk);
    chk({r, rn}, 32'h0000_0001);
    $display("power-up pulse done");
  endtask
  task automatic t_timeouts;
    wait_for(1, 0, n);
    rng(n, 58, 70);
    wait_for(0, 0, n);
    rng(n, 0, 2);
    wait_for(0, 1, n);
    rng(n, 10, 20);
    @(posedge clk) kick.level <= ~kick.level;
    repeat (2) @(posedge clk);
    chk(wen, 1);
    wait_for(1, 0, n);
    rng(n, 26, 38);
    wait_for(0, 1, n);
    tb_lvl <= 1;
    @(posedge clk) kick.level <= ~kick.level;
    repeat (2) @(posedge clk);
    chk(wen, 1);
    wait_for(1, 0, n);
    rng(n, 58, 70);
    wait_for(0, 1, n);
    tb_lvl <= 0;
    $display("timeout test done");
  endtask
  task automatic t_kick;
    @(posedge clk) host_en <= 1;
    bad = 0;
    repeat (300) @(posedge clk) if (rn !== 1'b1) bad++;
    chk(bad, 0);
    host_en <= 0;
    kick <= '{mid: 1'b1, level: 1'b0};
    bad = 0;
    repeat (200) @(posedge clk) if ({rn, wen} !== 2'b11) bad++;
    chk(bad, 0);
    $display("kick tests done");
  endtask
  task automatic t_supply;
    supply_pulse(10, 18);
    @(posedge clk) sup <= '{1'b0, 1'b1, 1'b0};
    repeat (2) @(posedge clk);
    chk(bk, 1);
    sup <= '{1'b0, 1'b0, 1'b0};
    repeat (2) @(posedge clk);
    chk(bk, 1);
    sup <= '{1'b0, 1'b0, 1'b1};
    repeat (2) @(posedge clk);
    chk(bk, 0);
    $display("supply tests done");
  endtask
  task automatic t_regs;
    wb(1, 4'h0, 32'h0000_0001);
    wb(0, 4'h0, '0);
    chk(q, 32'h0000_0001);
    wb(1, 4'h0, 32'h0000_0000, 4'h0);
    wb(0, 4'h0, '0);
    chk(q, 32'h0000_0001);
    wb(0, 4'h8, '0);
    chk(q, 32'h0000_0000);
    wb(0, 4'h4, '0);
    chk(q & 32'h0000_003F, 32'h0000_0017);
    supply_pulse(18, 26);
    wb(1, 4'h0, 32'h0000_0000);
    $display("register tests done");
  endtask
  task automatic t_ext;
    @(posedge clk) sel <= 0;
    ext <= 1;
    supply_pulse(2 * `SRW_EXT_RST_SHORT - 4,
                 2 * `SRW_EXT_RST_SHORT + 4);
    wb(0, 4'h4, '0);
    chk(q & 32'h0000_0020, 32'h0000_0020);
    @(posedge clk) kick <= '0;
    wait_for(1, 0, n);
    rng(n, 2 * `SRW_EXT_WD_POST - 8, 2 * `SRW_EXT_WD_POST + 8);
    $display("external timebase test done");
  endtask
  initial begin
    rstn = 0; sel = 1; tb_lvl = 0; ext = 0; we = 0; wcyc = 0; stb = 0;
    host_en = 0; adr = '0; wdat = '0; wsel = 4'hF; sup = '0; kick = '0;
    error_cnt = 0; checks = 0; cyc_n = 0;
    repeat (3) @(posedge clk);
    rstn <= 1;
    t_power_up;
    t_timeouts;
    t_kick;
    t_supply;
    t_regs;
    t_ext;
    summarize;
  end
endmodule
`default_nettype wire
